// ### hdl/ogtb_consts.vh
// offset and fine gain trim bank: addresses, field layout and reset values
// assumes byte addresses on a 12-bit register port with 16-bit data
`ifndef OGTB_CONSTS_VH
`define OGTB_CONSTS_VH

`define OGTB_ADDR_W 12
`define OGTB_DATA_W 16

`define OGTB_OFFS_A_SINGLE_INA_ADDR 12'h0348
`define OGTB_OFFS_A_SINGLE_INB_ADDR 12'h034a
`define OGTB_OFFS_B_INA_ADDR 12'h034c
`define OGTB_OFFS_B_INB_ADDR 12'h034e
`define OGTB_GAIN_A_BANK0_ADDR 12'h0350
`define OGTB_GAIN_A_BANK1_ADDR 12'h0351
`define OGTB_CTRL_ADDR 12'h0360
`define OGTB_STATUS_ADDR 12'h0362

`define OGTB_OFFS_W 12
`define OGTB_GAIN_W 5
`define OGTB_OFFS_REG_W 16
`define OGTB_GAIN_REG_W 8
`define OGTB_OFFS_RESET 16'h0000
`define OGTB_GAIN_RESET 8'h00

`define OGTB_CTRL_CAL_EN_BIT 0
`define OGTB_CTRL_SINGLE_BIT 1
`define OGTB_CTRL_INSEL_BIT 2
`define OGTB_CTRL_W 3
`define OGTB_CTRL_RESET 3'h0

`endif

// ### hdl/ogtb_trim_bank.v
// offset and fine gain trim register bank with correction routing
// assumes one 100 MHz clock, synchronous register strobes and stable fuse inputs
`timescale 1ns/1ns
`include "ogtb_consts.vh"

module ogtb_trim_bank #(
  parameter ADDR_W = `OGTB_ADDR_W,
  parameter DATA_W = `OGTB_DATA_W
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire [ADDR_W-1:0] ADDR,
  input wire [DATA_W-1:0] WDATA,
  input wire WRITE,
  input wire READ,
  output reg [DATA_W-1:0] RDATA,
  input wire [11:0] FUSE_OFFS_A_INA,
  input wire [11:0] FUSE_OFFS_A_INB,
  input wire [11:0] FUSE_OFFS_B_INA,
  input wire [11:0] FUSE_OFFS_B_INB,
  input wire [4:0] FUSE_GAIN_A0,
  input wire [4:0] FUSE_GAIN_A1,
  output reg [11:0] OFFS_A,
  output reg OFFS_A_VALID,
  output reg [11:0] OFFS_B,
  output reg OFFS_B_VALID,
  output reg [4:0] GAIN_A0,
  output reg [4:0] GAIN_A1,
  output reg GAIN_VALID
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg [15:0] offs_a_single_ina_trim_reg;
  reg [15:0] offs_a_single_inb_trim_reg;
  reg [15:0] offs_b_ina_trim_reg;
  reg [15:0] offs_b_inb_trim_reg;
  reg [7:0] fine_gain_a_bank0_dual_reg;
  reg [7:0] fine_gain_a_bank1_dual_reg;
  reg [2:0] ctrl_reg;
  reg fuse_loaded_reg;
  reg [DATA_W-1:0] rdata_next;

  wire cal_en = ctrl_reg[`OGTB_CTRL_CAL_EN_BIT];
  wire single_mode = ctrl_reg[`OGTB_CTRL_SINGLE_BIT];
  wire in_sel = ctrl_reg[`OGTB_CTRL_INSEL_BIT];
  wire wr_ok = WRITE && fuse_loaded_reg;

  function [11:0] offs_field;
    input [15:0] word;
    begin
      offs_field = word[11:0];
    end
  endfunction

  function addr_match;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write enables, held off during the fuse load cycle
  wire we_offs_a_ina = wr_ok && addr_match(ADDR, `OGTB_OFFS_A_SINGLE_INA_ADDR);
  wire we_offs_a_inb = wr_ok && addr_match(ADDR, `OGTB_OFFS_A_SINGLE_INB_ADDR);
  wire we_offs_b_ina = wr_ok && addr_match(ADDR, `OGTB_OFFS_B_INA_ADDR);
  wire we_offs_b_inb = wr_ok && addr_match(ADDR, `OGTB_OFFS_B_INB_ADDR);
  wire we_gain_a0 = wr_ok && addr_match(ADDR, `OGTB_GAIN_A_BANK0_ADDR);
  wire we_gain_a1 = wr_ok && addr_match(ADDR, `OGTB_GAIN_A_BANK1_ADDR);
  wire we_ctrl = wr_ok && addr_match(ADDR, `OGTB_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // registers: constant at reset, trim words take fuse defaults on the first edge after release
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fuse_loaded_reg <= 1'b0;
    end else begin
      fuse_loaded_reg <= 1'b1;
    end
  end

  // converter a, single mode, first input; reserved bits load as zero
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      offs_a_single_ina_trim_reg <= `OGTB_OFFS_RESET;
    end else if (!fuse_loaded_reg) begin
      offs_a_single_ina_trim_reg <= {4'h0, FUSE_OFFS_A_INA};
    end else if (we_offs_a_ina) begin
      offs_a_single_ina_trim_reg <= WDATA;
    end
  end

  // converter a, single mode, second input
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      offs_a_single_inb_trim_reg <= `OGTB_OFFS_RESET;
    end else if (!fuse_loaded_reg) begin
      offs_a_single_inb_trim_reg <= {4'h0, FUSE_OFFS_A_INB};
    end else if (we_offs_a_inb) begin
      offs_a_single_inb_trim_reg <= WDATA;
    end
  end

  // converter b, first input, single mode only
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      offs_b_ina_trim_reg <= `OGTB_OFFS_RESET;
    end else if (!fuse_loaded_reg) begin
      offs_b_ina_trim_reg <= {4'h0, FUSE_OFFS_B_INA};
    end else if (we_offs_b_ina) begin
      offs_b_ina_trim_reg <= WDATA;
    end
  end

  // converter b, second input, both modes
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      offs_b_inb_trim_reg <= `OGTB_OFFS_RESET;
    end else if (!fuse_loaded_reg) begin
      offs_b_inb_trim_reg <= {4'h0, FUSE_OFFS_B_INB};
    end else if (we_offs_b_inb) begin
      offs_b_inb_trim_reg <= WDATA;
    end
  end

  // converter a fine gain, bank 0
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fine_gain_a_bank0_dual_reg <= `OGTB_GAIN_RESET;
    end else if (!fuse_loaded_reg) begin
      fine_gain_a_bank0_dual_reg <= {3'h0, FUSE_GAIN_A0};
    end else if (we_gain_a0) begin
      fine_gain_a_bank0_dual_reg <= WDATA[7:0];
    end
  end

  // converter a fine gain, bank 1
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fine_gain_a_bank1_dual_reg <= `OGTB_GAIN_RESET;
    end else if (!fuse_loaded_reg) begin
      fine_gain_a_bank1_dual_reg <= {3'h0, FUSE_GAIN_A1};
    end else if (we_gain_a1) begin
      fine_gain_a_bank1_dual_reg <= WDATA[7:0];
    end
  end

  // mode control, no fuse default
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= `OGTB_CTRL_RESET;
    end else if (we_ctrl) begin
      ctrl_reg <= WDATA[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back, data valid only in the cycle after the strobe
  always @* begin
    rdata_next = {DATA_W{1'b0}};
    case (ADDR)
      `OGTB_OFFS_A_SINGLE_INA_ADDR: rdata_next = offs_a_single_ina_trim_reg;
      `OGTB_OFFS_A_SINGLE_INB_ADDR: rdata_next = offs_a_single_inb_trim_reg;
      `OGTB_OFFS_B_INA_ADDR: rdata_next = offs_b_ina_trim_reg;
      `OGTB_OFFS_B_INB_ADDR: rdata_next = offs_b_inb_trim_reg;
      `OGTB_GAIN_A_BANK0_ADDR: rdata_next = {8'h00, fine_gain_a_bank0_dual_reg};
      `OGTB_GAIN_A_BANK1_ADDR: rdata_next = {8'h00, fine_gain_a_bank1_dual_reg};
      `OGTB_CTRL_ADDR: rdata_next = {13'h0000, ctrl_reg};
      `OGTB_STATUS_ADDR: rdata_next = {12'h000, GAIN_VALID, OFFS_B_VALID, OFFS_A_VALID,
                                       fuse_loaded_reg};
      default: rdata_next = {DATA_W{1'b0}};
    endcase
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= {DATA_W{1'b0}};
    end else if (READ) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= {DATA_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // correction routing, code is {cal_en, single_mode, in_sel}
  localparam [2:0] route_off_dual_ina = 3'h0;
  localparam [2:0] route_off_dual_inb = 3'h1;
  localparam [2:0] route_off_single_ina = 3'h2;
  localparam [2:0] route_off_single_inb = 3'h3;
  localparam [2:0] route_dual_ina = 3'h4;
  localparam [2:0] route_dual_inb = 3'h5;
  localparam [2:0] route_single_ina = 3'h6;
  localparam [2:0] route_single_inb = 3'h7;
  wire [2:0] route_code = {cal_en, single_mode, in_sel};
  reg [11:0] offs_a_next;
  reg offs_a_valid_next;
  reg [11:0] offs_b_next;
  reg offs_b_valid_next;
  reg [4:0] gain_a0_next;
  reg [4:0] gain_a1_next;
  reg gain_valid_next;

  // converter a: only the single-mode words live here
  always @* begin
    offs_a_next = 12'h000;
    offs_a_valid_next = 1'b0;
    case (route_code)
      route_single_ina: begin
        offs_a_next = offs_field(offs_a_single_ina_trim_reg);
        offs_a_valid_next = 1'b1;
      end
      route_single_inb: begin
        offs_a_next = offs_field(offs_a_single_inb_trim_reg);
        offs_a_valid_next = 1'b1;
      end
      route_off_dual_ina, route_off_dual_inb, route_off_single_ina, route_off_single_inb: begin
        offs_a_next = 12'h000;
        offs_a_valid_next = 1'b0;
      end
      default: begin
        offs_a_next = 12'h000;
        offs_a_valid_next = 1'b0;
      end
    endcase
  end

  // converter b: dual mode always samples the second input
  always @* begin
    offs_b_next = 12'h000;
    offs_b_valid_next = 1'b0;
    case (route_code)
      route_single_ina: begin
        offs_b_next = offs_field(offs_b_ina_trim_reg);
        offs_b_valid_next = 1'b1;
      end
      route_single_inb: begin
        offs_b_next = offs_field(offs_b_inb_trim_reg);
        offs_b_valid_next = 1'b1;
      end
      route_dual_ina, route_dual_inb: begin
        offs_b_next = offs_field(offs_b_inb_trim_reg);
        offs_b_valid_next = 1'b1;
      end
      route_off_dual_ina, route_off_dual_inb, route_off_single_ina, route_off_single_inb: begin
        offs_b_next = 12'h000;
        offs_b_valid_next = 1'b0;
      end
      default: begin
        offs_b_next = 12'h000;
        offs_b_valid_next = 1'b0;
      end
    endcase
  end

  // fine gains only in dual mode
  always @* begin
    gain_a0_next = 5'h00;
    gain_a1_next = 5'h00;
    gain_valid_next = 1'b0;
    case (route_code)
      route_dual_ina, route_dual_inb: begin
        gain_a0_next = fine_gain_a_bank0_dual_reg[4:0];
        gain_a1_next = fine_gain_a_bank1_dual_reg[4:0];
        gain_valid_next = 1'b1;
      end
      route_off_dual_ina, route_off_dual_inb, route_off_single_ina, route_off_single_inb: begin
        gain_a0_next = 5'h00;
        gain_a1_next = 5'h00;
        gain_valid_next = 1'b0;
      end
      default: begin
        gain_a0_next = 5'h00;
        gain_a1_next = 5'h00;
        gain_valid_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs, one cycle behind the stored words and the mode
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OFFS_A <= 12'h000;
      OFFS_A_VALID <= 1'b0;
    end else begin
      OFFS_A <= offs_a_next;
      OFFS_A_VALID <= offs_a_valid_next;
    end
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OFFS_B <= 12'h000;
      OFFS_B_VALID <= 1'b0;
    end else begin
      OFFS_B <= offs_b_next;
      OFFS_B_VALID <= offs_b_valid_next;
    end
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      GAIN_A0 <= 5'h00;
      GAIN_A1 <= 5'h00;
      GAIN_VALID <= 1'b0;
    end else begin
      GAIN_A0 <= gain_a0_next;
      GAIN_A1 <= gain_a1_next;
      GAIN_VALID <= gain_valid_next;
    end
  end

endmodule

// ### bench/ogtb_trim_properties.sv
// port checker for the trim bank
// assumes binding onto the trim bank with its default port widths
`timescale 1ns/1ns
module ogtb_trim_props (
  input wire CLOCK,
  input wire ARST_N,
  input wire [11:0] ADDR,
  input wire [15:0] WDATA,
  input wire WRITE,
  input wire READ,
  input wire [15:0] RDATA,
  input wire [11:0] OFFS_A,
  input wire OFFS_A_VALID,
  input wire [11:0] OFFS_B,
  input wire OFFS_B_VALID,
  input wire [4:0] GAIN_A0,
  input wire [4:0] GAIN_A1,
  input wire GAIN_VALID
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
////////////////////////////////////////////////////////////////////////////////
  chk_rdata_quiet: assert property (!$past(READ) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  chk_wr_readback: assert property (WRITE && ADDR == 12'h034c ##1 READ && ADDR == 12'h034c
    |=> RDATA == $past(WDATA, 2)) else $error("offset word did not read back");
  chk_offs_a_idle: assert property (!OFFS_A_VALID |-> OFFS_A == 12'h000)
    else $error("offset a driven while not valid");
  chk_offs_b_idle: assert property (!OFFS_B_VALID |-> OFFS_B == 12'h000)
    else $error("offset b driven while not valid");
  chk_gain_idle: assert property (!GAIN_VALID |-> GAIN_A0 == 5'h00 && GAIN_A1 == 5'h00)
    else $error("gain driven while not valid");
  chk_mode_excl: assert property (!(OFFS_A_VALID && GAIN_VALID))
    else $error("single and dual corrections both valid");
  chk_a_needs_cal: assert property (OFFS_A_VALID |-> OFFS_B_VALID)
    else $error("offset a valid without calibration");
  chk_gain_needs_cal: assert property (GAIN_VALID |-> OFFS_B_VALID)
    else $error("gain valid without calibration");
  chk_route_hold: assert property (!$past(WRITE) && !$past(WRITE, 2)
    |-> $stable(OFFS_A) && $stable(OFFS_B) && $stable(GAIN_A1)) else $error("route moved");
  cover property (OFFS_A_VALID);
  cover property (GAIN_VALID);
  cover property (READ ##1 RDATA != 16'h0000);
endmodule

// ### bench/ogtb_trim_bank_tb.sv
// bench for the trim bank: fuse defaults, read back and routing
// assumes the trim bank and its checker are compiled before this file
`timescale 1ns/1ns
`include "ogtb_consts.vh"
module ogtb_trim_bank_tb;
  reg CLOCK = 0;
  reg ARST_N = 0;
  reg [11:0] ADDR = 0;
  reg [15:0] WDATA = 0;
  reg WRITE = 0;
  reg READ = 0;
  reg [11:0] fo [0:3];
  reg [4:0] fg [0:1];
  reg [15:0] dv [0:5];
  reg [11:0] am [0:5];
  reg [36:0] exp_o;
  wire [15:0] RDATA;
  wire [11:0] oa, ob;
  wire [4:0] g0, g1;
  wire va, vb, vg;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i, p;
  ogtb_trim_bank dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .FUSE_OFFS_A_INA(fo[0]),
    .FUSE_OFFS_A_INB(fo[1]), .FUSE_OFFS_B_INA(fo[2]), .FUSE_OFFS_B_INB(fo[3]),
    .FUSE_GAIN_A0(fg[0]), .FUSE_GAIN_A1(fg[1]), .OFFS_A(oa), .OFFS_A_VALID(va),
    .OFFS_B(ob), .OFFS_B_VALID(vb), .GAIN_A0(g0), .GAIN_A1(g1), .GAIN_VALID(vg));
  always #5 CLOCK = ~CLOCK;
////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [36:0] e, input [36:0] s);
    begin
      check_count = check_count + 1;
      if (e !== s) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // strobe tasks start just after an edge and leave the strobe up for chaining
  task wr(input [11:0] a, input [15:0] d);
    begin
      ADDR <= a;
      WDATA <= d;
      WRITE <= 1'b1;
      READ <= 1'b0;
      @(posedge CLOCK);
    end
  endtask
  task rd(input [11:0] a, input [15:0] e);
    begin
      ADDR <= a;
      READ <= 1'b1;
      WRITE <= 1'b0;
      @(posedge CLOCK);
      #1 chk("rdata", {21'h0, e}, {21'h0, RDATA});
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge CLOCK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  initial begin
    am[0] = `OGTB_OFFS_A_SINGLE_INA_ADDR;
    am[1] = `OGTB_OFFS_A_SINGLE_INB_ADDR;
    am[2] = `OGTB_OFFS_B_INA_ADDR;
    am[3] = `OGTB_OFFS_B_INB_ADDR;
    am[4] = `OGTB_GAIN_A_BANK0_ADDR;
    am[5] = `OGTB_GAIN_A_BANK1_ADDR;
    for (p = 0; p < 2; p = p + 1) begin
      for (i = 0; i < 4; i = i + 1) fo[i] = 12'h0a53 + 12'h0111 * i[11:0] + {11'h000, p[0]};
      for (i = 0; i < 2; i = i + 1) fg[i] = 5'h15 - i[4:0] - {4'h0, p[0]};
      ARST_N <= 1'b0;
      repeat (20) @(posedge CLOCK);
      ARST_N <= 1'b1;
      repeat (2) @(posedge CLOCK);
      for (i = 0; i < 6; i = i + 1) rd(am[i], i < 4 ? {4'h0, fo[i]} : {11'h000, fg[i-4]});
      READ <= 1'b0;
    end
    for (i = 0; i < 6; i = i + 1) begin
      dv[i] = (i < 4) ? 16'h95c0 + i[15:0] * 16'h1111 : 16'h00e0 + i[15:0];
      wr(am[i], dv[i]);
      rd(am[i], dv[i]);
    end
    rd(12'h0300, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`OGTB_CTRL_ADDR, {13'h0000, i[2:0]});
      WRITE <= 1'b0;
      repeat (2) @(posedge CLOCK);
      exp_o[36:24] = (i[1:0] == 2'b11) ? {1'b1, i[2] ? dv[1][11:0] : dv[0][11:0]} : 13'h0000;
      exp_o[23:11] = i[0] ? {1'b1, (i[1] & !i[2]) ? dv[2][11:0] : dv[3][11:0]} : 13'h0000;
      exp_o[10:0] = (i[1:0] == 2'b01) ? {1'b1, dv[4][4:0], dv[5][4:0]} : 11'h000;
      #1 chk("route", exp_o, {va, oa, vb, ob, vg, g0, g1});
    end
    rd(`OGTB_CTRL_ADDR, 16'h0007);
    rd(`OGTB_STATUS_ADDR, 16'h0007);
    tally_and_finish;
  end
endmodule
bind ogtb_trim_bank ogtb_trim_props u_props (.*);
